// *** rtl/ecp_config_status.sv ***
`timescale 1ns/100ps
// Summary of operation
// [R1] Config register A always reads 0x10.
// [R2] Config register A is read only; writes change nothing.
// [R3] Config register B is read only and reports interrupt line state.
// [R4] Config register B bit 7 always reads zero.
// [R5] Config register B bit 6 shows the live interrupt pin level.
// [R6] While service bit is clear, a service event interrupts and sets it.
// [R7] Event: DMA enable set and terminal count during DMA.
// [R8] Event: DMA enable clear, qualifier set, eight or more FIFO bytes.
// [R9] Config register B bits 5:4 read 11 for line 5, 00 for line 7.
// [R10] Config register B bit 3 reads one, bits 2:0 zero, writes ignored.
// [R11] No further service events while the service bit stays set.
module ecp_config_status
    import ecp_pkg::*;
#(
    parameter int CNT_W  = ECP_CNT_W,
    parameter int THRESH = ECP_FIFO_THRESH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Port pins and configuration
    input  wire logic             irq_pin_level,
    input  wire logic             irq_line5_sel,
    input  wire logic             dma_tc,
    input  wire logic             port_dma_acknowledge,
    input  wire logic [CNT_W-1:0] fifo_count,
    // Outputs
    output logic                  dma_enable,
    output logic                  service_irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ecp_aphase_t           aph_q;
    ecp_pins_t             pins_raw;
    ecp_pins_t             pins_s;
    logic [7:0]            ecr_q;
    logic [ECP_NUM_EV-1:0] stat_q;
    logic [ECP_NUM_EV-1:0] en_q;
    logic [ECP_NUM_EV-1:0] ev;
    logic [ECP_NUM_EV-1:0] clr_bits;
    logic                  addr_take;
    logic                  wr_ecr;
    logic                  wr_clr;
    logic                  wr_en;
    logic                  thr_met;
    logic [7:0]            cfg_b;
    logic [31:0]           rd_d;
    logic [31:0]           hrdata_q;
    logic                  irq_q;
    logic                  svc_set;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------

    // Asynchronous pins gathered for the synchroniser
    assign pins_raw.irq_pin = irq_pin_level;
    assign pins_raw.tc      = dma_tc;
    assign pins_raw.dma_ack = port_dma_acknowledge;

    // Two flops before any logic reads the pins
    ecp_sync #(
        .W ($bits(ecp_pins_t))
    ) u_pin_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (pins_raw),
        .q      (pins_s)
    );

    // ------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------

    // A transfer is taken when selected, active and the bus is ready
    assign addr_take = hsel && hready &&
                       (htrans == ECP_HTRANS_NONSEQ || htrans == ECP_HTRANS_SEQ);

    // Capture the address phase for the following data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aph_q <= '0;
        end else if (hready) begin
            aph_q.valid <= addr_take;
            aph_q.write <= hwrite;
            aph_q.addr  <= haddr[7:0];
        end
    end

    // Write strobes, used in the data phase with hwdata
    assign wr_ecr = aph_q.valid && aph_q.write && (aph_q.addr == ECP_OFS_ECR);
    assign wr_clr = aph_q.valid && aph_q.write && (aph_q.addr == ECP_OFS_IRQ_CLR);
    assign wr_en  = aph_q.valid && aph_q.write && (aph_q.addr == ECP_OFS_IRQ_EN);

    // ------------------------------------------------------------
    // Configuration register B contents
    // ------------------------------------------------------------

    // Fixed bits, line select bits and the live interrupt pin level
    always_comb begin
        cfg_b                   = '0;             // R4 R10
        cfg_b[ECP_CFGB_IRQ_LVL] = pins_s.irq_pin; // R5
        cfg_b[ECP_CFGB_SEL_HI]  = irq_line5_sel;  // R9
        cfg_b[ECP_CFGB_SEL_LO]  = irq_line5_sel;  // R9
        cfg_b[ECP_CFGB_ONE]     = 1'b1;           // R10
    end

    // ------------------------------------------------------------
    // Service events
    // ------------------------------------------------------------

    // FIFO holds at least the threshold number of bytes
    assign thr_met = (fifo_count >= CNT_W'(THRESH));

    // Events only fire while the service bit is clear
    always_comb begin
        ev             = '0;
        ev[ECP_EV_TC]  = ecr_q[ECP_ECR_DMA_EN] && pins_s.tc && pins_s.dma_ack &&
                         !ecr_q[ECP_ECR_SERVICE];             // R7 R11
        ev[ECP_EV_THR] = !ecr_q[ECP_ECR_DMA_EN] && ecr_q[ECP_ECR_THR_QUAL] &&
                         thr_met && !ecr_q[ECP_ECR_SERVICE];  // R8 R11
    end

    // Any event raises the service bit
    assign svc_set = |ev; // R6

    // ------------------------------------------------------------
    // Extended control register
    // ------------------------------------------------------------

    // Software writes; a service event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ecr_q <= ECP_ECR_RESET;
        end else begin
            if (wr_ecr) begin
                ecr_q <= hwdata[7:0];
            end
            if (svc_set) begin
                ecr_q[ECP_ECR_SERVICE] <= 1'b1; // R6
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------

    // Bits to clear from a write of ones
    assign clr_bits = wr_clr ? hwdata[ECP_NUM_EV-1:0] : '0;

    // Sticky status; a new event wins over a clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr_bits) | ev; // R6
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= '0;
        end else if (wr_en) begin
            en_q <= hwdata[ECP_NUM_EV-1:0];
        end
    end

    // Level interrupt while an enabled status bit is set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((stat_q & ~clr_bits) | ev) & en_q); // R6
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------

    // Select read data during the address phase
    always_comb begin
        rd_d = '0;
        case (haddr[7:0])
            ECP_OFS_CFG_A: begin
                rd_d[7:0] = ECP_CFG_A_VALUE; // R1 R2
            end
            ECP_OFS_CFG_B: begin
                rd_d[7:0] = cfg_b; // R3
            end
            ECP_OFS_ECR: begin
                rd_d[7:0] = ecr_q;
            end
            ECP_OFS_IRQ_STAT: begin
                rd_d[ECP_NUM_EV-1:0] = stat_q;
            end
            ECP_OFS_IRQ_EN: begin
                rd_d[ECP_NUM_EV-1:0] = en_q;
            end
            default: begin
                rd_d = '0; // Unmapped and clear register read zero
            end
        endcase
    end

    // Register read data for the data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_q <= '0;
        end else if (addr_take && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Zero wait state, always OKAY
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata      = hrdata_q;
    assign service_irq = irq_q;
    assign dma_enable  = ecr_q[ECP_ECR_DMA_EN];

endmodule

// *** rtl/ecp_pkg.sv ***
package ecp_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ECP_OFS_CFG_A    = 8'h00;  // fixed_port_config_a
    localparam logic [7:0] ECP_OFS_CFG_B    = 8'h04;  // interrupt_line_config_b
    localparam logic [7:0] ECP_OFS_ECR      = 8'h08;  // extended_control_reg
    localparam logic [7:0] ECP_OFS_IRQ_STAT = 8'h0c;  // Sticky event status
    localparam logic [7:0] ECP_OFS_IRQ_CLR  = 8'h10;  // Write one to clear
    localparam logic [7:0] ECP_OFS_IRQ_EN   = 8'h14;  // Interrupt enable

    // ------------------------------------------------------------
    // Fixed values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] ECP_CFG_A_VALUE  = 8'h10;
    localparam int         ECP_CFGB_IRQ_LVL = 6;
    localparam int         ECP_CFGB_SEL_HI  = 5;
    localparam int         ECP_CFGB_SEL_LO  = 4;
    localparam int         ECP_CFGB_ONE     = 3;
    localparam int         ECP_ECR_THR_QUAL = 4;
    localparam int         ECP_ECR_DMA_EN   = 3;
    localparam int         ECP_ECR_SERVICE  = 2;
    localparam logic [7:0] ECP_ECR_RESET    = 8'h04;  // Service set: interrupts held off
    localparam int         ECP_EV_TC        = 0;
    localparam int         ECP_EV_THR       = 1;
    localparam int         ECP_NUM_EV       = 2;
    localparam int         ECP_FIFO_THRESH  = 8;
    localparam int         ECP_CNT_W        = 5;

    // ------------------------------------------------------------
    // AHB transfer codes
    // ------------------------------------------------------------
    localparam logic [1:0] ECP_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] ECP_HTRANS_SEQ    = 2'h3;

    // Captured address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ecp_aphase_t;

    // Pin inputs after synchronisation
    typedef struct packed {
        logic irq_pin;
        logic tc;
        logic dma_ack;
    } ecp_pins_t;

endpackage

// *** rtl/ecp_sync.sv ***
`timescale 1ns/100ps
module ecp_sync
    import ecp_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Two flip-flop synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// *** tb/ecp_config_status_bench.sv ***
`timescale 1ns/100ps
module ecp_config_status_bench
    import ecp_pkg::*;
;
    logic                 clk, arst_n, hsel, hwrite, pin, sel, go, tc, ack;
    logic                 hreadyout, hresp, dma_en, irq;
    logic [31:0]          haddr, hwdata, hrdata, rd;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [ECP_CNT_W-1:0] fifo;
    logic [17:0]          rows [9];
    int                   bad_count, total_checks, cyc;
    ecp_config_status #(.CNT_W(ECP_CNT_W), .THRESH(ECP_FIFO_THRESH)) dut_u (
        .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pin_level(pin),
        .irq_line5_sel(sel), .dma_tc(tc), .port_dma_acknowledge(ack), .fifo_count(fifo),
        .dma_enable(dma_en), .service_irq(irq));
    ecp_dma_model dma_u (.clk(clk), .arst_n(arst_n), .go(go), .dma_tc(tc),
        .port_dma_acknowledge(ack));
    // Clock and hang limit
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    task end_of_test();
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One single transfer, waiting on ready in both phases
    task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= ECP_HTRANS_NONSEQ; hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task wt(input int n, input string nm, input logic e);
        repeat (n) @(posedge clk);
        chk(nm, {31'h0, e}, {31'h0, irq});
    endtask
    // Main sequence: table of reads, then event cases
    initial begin
        arst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; pin = 1'b0; sel = 1'b0; go = 1'b0; fifo = '0;
        rows = '{{8'h08, 2'h0, 8'h04}, {8'h0c, 2'h0, 8'h00}, {8'h00, 2'h0, 8'h10},
            {8'h00, 2'h3, 8'h10}, {8'h04, 2'h0, 8'h08}, {8'h04, 2'h2, 8'h48},
            {8'h04, 2'h1, 8'h38}, {8'h04, 2'h3, 8'h78}, {8'h20, 2'h3, 8'h00}};
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            pin <= rows[i][9]; sel <= rows[i][8];
            repeat (4) @(posedge clk);
            ahb(rows[i][17:10], 1'b0, 32'h0, rd);
            chk("table read", {24'h0, rows[i][7:0]}, rd);
        end
        ahb(ECP_OFS_CFG_A, 1'b1, 32'hff, rd);
        ahb(ECP_OFS_CFG_B, 1'b1, 32'h00, rd);
        ahb(ECP_OFS_CFG_A, 1'b0, 32'h0, rd);
        chk("cfg a after write", 32'h10, rd);
        ahb(ECP_OFS_CFG_B, 1'b0, 32'h0, rd);
        chk("cfg b after write", 32'h78, rd);
        ahb(ECP_OFS_ECR, 1'b0, 32'h0, rd);
        chk("ecr after ro writes", 32'h04, rd);
        fifo <= 5'd7;
        ahb(ECP_OFS_IRQ_EN, 1'b1, 32'h3, rd);
        ahb(ECP_OFS_ECR, 1'b1, 32'h10, rd);
        wt(4, "irq below threshold", 1'b0);
        fifo <= 5'd8;
        wt(4, "irq at threshold", 1'b1);
        ahb(ECP_OFS_IRQ_STAT, 1'b0, 32'h0, rd);
        chk("status threshold", 32'h2, rd);
        ahb(ECP_OFS_ECR, 1'b0, 32'h0, rd);
        chk("service set", 32'h14, rd);
        ahb(ECP_OFS_IRQ_CLR, 1'b1, 32'h3, rd);
        wt(4, "no rearm", 1'b0);
        ahb(ECP_OFS_ECR, 1'b1, 32'h18, rd);
        wt(4, "threshold off in dma", 1'b0);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wt(8, "irq terminal count", 1'b1);
        ahb(ECP_OFS_IRQ_STAT, 1'b0, 32'h0, rd);
        chk("status tc", 32'h1, rd);
        arst_n <= 1'b0;
        wt(2, "irq in reset", 1'b0);
        arst_n <= 1'b1;
        @(posedge clk);
        ahb(ECP_OFS_ECR, 1'b0, 32'h0, rd);
        chk("ecr after reset", 32'h04, rd);
        end_of_test();
    end
endmodule

// *** tb/ecp_config_status_props.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks
// ------------------------------------------------------------
module ecp_config_status_props
    import ecp_pkg::*;
#(
    parameter int CNT_W  = ECP_CNT_W,
    parameter int THRESH = ECP_FIFO_THRESH
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             arst_n,
    // Bus
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [2:0]       hsize,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    // Pins
    input wire logic             irq_pin_level,
    input wire logic             irq_line5_sel,
    input wire logic             dma_tc,
    input wire logic             port_dma_acknowledge,
    input wire logic [CNT_W-1:0] fifo_count,
    input wire logic             dma_enable,
    input wire logic             service_irq
);
    logic tk, rd_a, rd_b, wr_e, wr_any;
    // Taken transfers by kind
    assign tk     = hsel && hready && htrans[1];
    assign rd_a   = tk && !hwrite && haddr[7:0] == ECP_OFS_CFG_A;
    assign rd_b   = tk && !hwrite && haddr[7:0] == ECP_OFS_CFG_B;
    assign wr_e   = tk && hwrite && haddr[7:0] == ECP_OFS_ECR;
    assign wr_any = tk && hwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_cfga; rd_a |=> hrdata == 32'h10; endproperty
    a_cfga: assert property (p_cfga) else $error("cfg a value");
    property p_ok; hreadyout && !hresp; endproperty
    a_ok: assert property (p_ok) else $error("bus not ready or okay");
    property p_hold; !(tk && !hwrite) |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_b7; rd_b |=> !hrdata[7]; endproperty
    a_b7: assert property (p_b7) else $error("cfg b bit 7");
    property p_pin;
        $stable(irq_pin_level)[*3] ##1 (rd_b && $stable(irq_pin_level)) |=>
            hrdata[6] == $past(irq_pin_level);
    endproperty
    a_pin: assert property (p_pin) else $error("cfg b pin level");
    property p_sel; rd_b |=> hrdata[5:4] == {2{$past(irq_line5_sel)}}; endproperty
    a_sel: assert property (p_sel) else $error("cfg b line select");
    property p_low; rd_b |=> hrdata[3:0] == 4'h8 && hrdata[31:8] == 24'h0; endproperty
    a_low: assert property (p_low) else $error("cfg b fixed bits");
    property p_dma; wr_e |=> ##1 dma_enable == $past(hwdata[3]); endproperty
    a_dma: assert property (p_dma) else $error("dma enable update");
    property p_fall;
        $fell(service_irq) |-> $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3);
    endproperty
    a_fall: assert property (p_fall) else $error("irq fell without write");
endmodule
bind ecp_config_status ecp_config_status_props #(.CNT_W(CNT_W), .THRESH(THRESH)) u_props (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_pin_level(irq_pin_level),
    .irq_line5_sel(irq_line5_sel), .dma_tc(dma_tc),
    .port_dma_acknowledge(port_dma_acknowledge), .fifo_count(fifo_count),
    .dma_enable(dma_enable), .service_irq(service_irq));

// *** tb/ecp_dma_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// DMA side model
// ------------------------------------------------------------
module ecp_dma_model (
    // Clock, reset, command
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic go,
    // DMA pins
    output logic      dma_tc,
    output logic      port_dma_acknowledge
);
    logic [2:0] cnt_q;
    // Four acknowledge cycles per burst
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 3'h0;
        end else if (go && cnt_q == 3'h0) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // Count ends the burst, pins idle low
    assign port_dma_acknowledge = cnt_q != 3'h0;
    assign dma_tc = cnt_q != 3'h0 && cnt_q < 3'h3;
endmodule
